//--- hdl/dma_register_map.sv
// Register bank and address decoder of the two-channel DMA engine
`timescale 1ns/1ps
`include "dma_regs_defs.svh"

module dma_register_map
  import dma_regs_pkg::*;
#(
  parameter logic [31:0] REGISTER_BASE_PARAMETER = 32'h0000_0000,
  parameter bit CHAINING_MODE = 1'b1,
  parameter bit MULTICHANNEL = 1'b0
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [31:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [31:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire logic TX_IDLE_IN,
  input wire logic RX_IDLE_IN,
  input wire logic [2:0] TX_EVENT_IN,
  input wire logic [2:0] RX_EVENT_IN,
  output logic [31:0] TX_CONTROL_OUT,
  output logic [31:0] RX_CONTROL_OUT,
  output logic [31:0] TX_ADDR_LOW_OUT,
  output logic [31:0] TX_ADDR_HIGH_OUT,
  output logic [31:0] RX_ADDR_LOW_OUT,
  output logic [31:0] RX_ADDR_HIGH_OUT,
  output logic [31:0] TX_LENGTH_OUT,
  output logic [31:0] RX_LENGTH_OUT,
  output logic TX_START_OUT,
  output logic RX_START_OUT,
  output logic [31:0] CHAIN_ATTR_OUT
);

  localparam int NUM_CHAN = 2;

  // Bus handshake state
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic arready_ff;
  logic rvalid_ff;
  reg_word_t rdata_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;

  logic wr_fire;
  logic rd_fire;
  logic [31:0] wr_ofs_full;
  logic [31:0] rd_ofs_full;
  logic wr_hit;
  logic rd_hit;
  reg_offset_t wr_ofs;
  reg_offset_t rd_ofs;

  // Per-channel storage and the shared attribute word
  reg_word_t ctrl_ff [NUM_CHAN];
  reg_word_t cur_lo_ff [NUM_CHAN];
  reg_word_t cur_hi_ff [NUM_CHAN];
  reg_word_t tail_lo_ff [NUM_CHAN];
  reg_word_t tail_hi_ff [NUM_CHAN];
  reg_word_t addr_lo_ff [NUM_CHAN];
  reg_word_t addr_hi_ff [NUM_CHAN];
  reg_word_t len_ff [NUM_CHAN];
  event_bits_t evt_ff [NUM_CHAN];
  logic halted_ff [NUM_CHAN];
  logic start_ff [NUM_CHAN];
  reg_word_t attr_ff;

  logic idle_in [NUM_CHAN];
  event_bits_t evt_in [NUM_CHAN];
  reg_word_t rd_chan_word [NUM_CHAN];
  reg_word_t rd_word;
  logic attr_present;

  assign idle_in[0] = TX_IDLE_IN;
  assign idle_in[1] = RX_IDLE_IN;
  assign evt_in[0] = TX_EVENT_IN;
  assign evt_in[1] = RX_EVENT_IN;
  assign attr_present = CHAINING_MODE && MULTICHANNEL;

  // A write is taken only with address and data offered in the same cycle
  assign wr_fire = AWVALID_IN && awready_ff && WVALID_IN && wready_ff;
  assign rd_fire = ARVALID_IN && arready_ff;

  // Addresses become offsets from the configured base of the bank
  assign wr_ofs_full = AWADDR_IN - REGISTER_BASE_PARAMETER;
  assign rd_ofs_full = ARADDR_IN - REGISTER_BASE_PARAMETER;
  assign wr_hit = (wr_ofs_full < `DMA_REG_SPAN) && (wr_ofs_full[1:0] == 2'h0);
  assign rd_hit = (rd_ofs_full < `DMA_REG_SPAN) && (rd_ofs_full[1:0] == 2'h0);
  assign wr_ofs = wr_ofs_full[7:0];
  assign rd_ofs = rd_ofs_full[7:0];

  // Write address and data are accepted in one shared beat
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else if (awready_ff) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else if (AWVALID_IN && WVALID_IN && !bvalid_ff) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `DMA_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= `DMA_RESP_OKAY;
    end else if (BREADY_IN) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel: one outstanding read at a time
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      arready_ff <= 1'b0;
    end else if (arready_ff) begin
      arready_ff <= 1'b0;
    end else if (ARVALID_IN && !rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `DMA_WORD_RESET;
      rresp_ff <= `DMA_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_hit ? rd_word : `DMA_WORD_RESET;
      rresp_ff <= `DMA_RESP_OKAY;
    end else if (RREADY_IN) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Shared attribute word, present only in multichannel chaining builds
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      attr_ff <= `DMA_WORD_RESET;
    end else if (attr_present && wr_fire && wr_hit && wr_ofs == `DMA_CHAIN_ATTR_OFS) begin
      attr_ff <= WDATA_IN;
    end
  end

  generate
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      localparam reg_offset_t BASE = reg_offset_t'(ch * 8'h30);
      logic in_win_w;
      logic in_win_r;
      reg_offset_t lw;
      reg_offset_t lr;
      logic wr_ctrl;
      logic wr_stat;
      logic wr_cur_lo;
      logic wr_cur_hi;
      logic wr_tail_lo;
      logic wr_tail_hi;
      logic wr_addr_lo;
      logic wr_addr_hi;
      logic wr_len;
      event_bits_t clr;

      assign in_win_w = wr_fire && wr_hit && (wr_ofs >= BASE)
                        && (wr_ofs < BASE + `DMA_CHANNEL_STRIDE);
      assign in_win_r = rd_hit && (rd_ofs >= BASE) && (rd_ofs < BASE + `DMA_CHANNEL_STRIDE);
      assign lw = wr_ofs - BASE;
      assign lr = rd_ofs - BASE;

      // Control and status sit at the same place in both modes
      assign wr_ctrl = in_win_w && lw == `DMA_TX_CONTROL_OFS;
      assign wr_stat = in_win_w && lw == `DMA_TX_STATUS_OFS;
      assign wr_cur_lo = CHAINING_MODE && in_win_w && lw == `DMA_TX_CUR_DESC_LOW_OFS;
      assign wr_cur_hi = CHAINING_MODE && in_win_w && lw == `DMA_TX_CUR_DESC_HIGH_OFS;
      assign wr_tail_lo = CHAINING_MODE && in_win_w && lw == `DMA_TX_TAIL_DESC_LOW_OFS;
      assign wr_tail_hi = CHAINING_MODE && in_win_w && lw == `DMA_TX_TAIL_DESC_HIGH_OFS;
      assign wr_addr_lo = !CHAINING_MODE && in_win_w && lw == `DMA_TX_SOURCE_LOW_OFS;
      assign wr_addr_hi = !CHAINING_MODE && in_win_w && lw == `DMA_TX_SOURCE_HIGH_OFS;
      assign wr_len = !CHAINING_MODE && in_win_w && lw == `DMA_TX_LENGTH_OFS;

      // Read-only control bits keep their value whatever is written
      always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
          ctrl_ff[ch] <= `DMA_CONTROL_RESET;
        end else if (wr_ctrl) begin
          ctrl_ff[ch] <= (WDATA_IN & ~`DMA_CONTROL_RO_MASK) | `DMA_CONTROL_RESET;
        end
      end

      always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
          cur_lo_ff[ch] <= `DMA_WORD_RESET;
          cur_hi_ff[ch] <= `DMA_WORD_RESET;
          tail_lo_ff[ch] <= `DMA_WORD_RESET;
          tail_hi_ff[ch] <= `DMA_WORD_RESET;
        end else begin
          if (wr_cur_lo) begin
            cur_lo_ff[ch] <= WDATA_IN;
          end
          if (wr_cur_hi) begin
            cur_hi_ff[ch] <= WDATA_IN;
          end
          if (wr_tail_lo) begin
            tail_lo_ff[ch] <= WDATA_IN;
          end
          if (wr_tail_hi) begin
            tail_hi_ff[ch] <= WDATA_IN;
          end
        end
      end

      always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
          addr_lo_ff[ch] <= `DMA_WORD_RESET;
          addr_hi_ff[ch] <= `DMA_WORD_RESET;
          len_ff[ch] <= `DMA_WORD_RESET;
        end else begin
          if (wr_addr_lo) begin
            addr_lo_ff[ch] <= WDATA_IN;
          end
          if (wr_addr_hi) begin
            addr_hi_ff[ch] <= WDATA_IN;
          end
          if (wr_len) begin
            len_ff[ch] <= WDATA_IN;
          end
        end
      end

      // Sticky event bits: writing one clears, a new event in the same cycle wins
      assign clr = wr_stat ? WDATA_IN[`DMA_STATUS_EVENT_LSB +: `DMA_EVENT_W] : 3'h0;
      always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
          evt_ff[ch] <= 3'h0;
        end else begin
          evt_ff[ch] <= (evt_ff[ch] & ~clr) | evt_in[ch];
        end
      end

      // Halted tracks the run bit; it cannot be written
      always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
          halted_ff[ch] <= 1'b1;
        end else begin
          halted_ff[ch] <= !ctrl_ff[ch][`DMA_CONTROL_RUN_BIT];
        end
      end

      // Start pulse: tail pointer low word in chaining mode, length in direct mode
      always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
          start_ff[ch] <= 1'b0;
        end else begin
          start_ff[ch] <= CHAINING_MODE ? wr_tail_lo : wr_len;
        end
      end

      // Read decode; anything not implemented in this mode reads zero
      always_comb begin
        rd_chan_word[ch] = `DMA_WORD_RESET;
        if (in_win_r) begin
          case (lr)
            `DMA_TX_CONTROL_OFS: rd_chan_word[ch] = ctrl_ff[ch];
            `DMA_TX_STATUS_OFS: begin
              rd_chan_word[ch][`DMA_STATUS_HALTED_BIT] = halted_ff[ch];
              rd_chan_word[ch][`DMA_STATUS_IDLE_BIT] = idle_in[ch];
              rd_chan_word[ch][`DMA_STATUS_EVENT_LSB +: `DMA_EVENT_W] = evt_ff[ch];
            end
            `DMA_TX_CUR_DESC_LOW_OFS: rd_chan_word[ch] = CHAINING_MODE ? cur_lo_ff[ch] : '0;
            `DMA_TX_CUR_DESC_HIGH_OFS: rd_chan_word[ch] = CHAINING_MODE ? cur_hi_ff[ch] : '0;
            `DMA_TX_TAIL_DESC_LOW_OFS: rd_chan_word[ch] = CHAINING_MODE ? tail_lo_ff[ch] : '0;
            `DMA_TX_TAIL_DESC_HIGH_OFS: rd_chan_word[ch] = CHAINING_MODE ? tail_hi_ff[ch] : '0;
            `DMA_TX_SOURCE_LOW_OFS: rd_chan_word[ch] = CHAINING_MODE ? '0 : addr_lo_ff[ch];
            `DMA_TX_SOURCE_HIGH_OFS: rd_chan_word[ch] = CHAINING_MODE ? '0 : addr_hi_ff[ch];
            `DMA_TX_LENGTH_OFS: rd_chan_word[ch] = CHAINING_MODE ? '0 : len_ff[ch];
            `DMA_CHAIN_ATTR_OFS: begin
              if (ch == 0 && attr_present) begin
                rd_chan_word[ch] = attr_ff;
              end
            end
            default: rd_chan_word[ch] = `DMA_WORD_RESET;
          endcase
        end
      end
    end
  endgenerate

  assign rd_word = rd_chan_word[0] | rd_chan_word[1];

  // Strobes play no part; every write is a full word
  assign AWREADY_OUT = awready_ff;
  assign WREADY_OUT = wready_ff;
  assign BVALID_OUT = bvalid_ff;
  assign BRESP_OUT = bresp_ff;
  assign ARREADY_OUT = arready_ff;
  assign RVALID_OUT = rvalid_ff;
  assign RDATA_OUT = rdata_ff;
  assign RRESP_OUT = rresp_ff;

  assign TX_CONTROL_OUT = ctrl_ff[0];
  assign RX_CONTROL_OUT = ctrl_ff[1];
  assign TX_ADDR_LOW_OUT = CHAINING_MODE ? cur_lo_ff[0] : addr_lo_ff[0];
  assign TX_ADDR_HIGH_OUT = CHAINING_MODE ? cur_hi_ff[0] : addr_hi_ff[0];
  assign RX_ADDR_LOW_OUT = CHAINING_MODE ? cur_lo_ff[1] : addr_lo_ff[1];
  assign RX_ADDR_HIGH_OUT = CHAINING_MODE ? cur_hi_ff[1] : addr_hi_ff[1];
  assign TX_LENGTH_OUT = len_ff[0];
  assign RX_LENGTH_OUT = len_ff[1];
  assign TX_START_OUT = start_ff[0];
  assign RX_START_OUT = start_ff[1];
  assign CHAIN_ATTR_OUT = attr_ff;

endmodule : dma_register_map

//--- hdl/dma_regs_defs.svh
// Offsets, field positions and reset values of the DMA register bank
`ifndef DMA_REGS_DEFS_SVH
`define DMA_REGS_DEFS_SVH

`define DMA_TX_CONTROL_OFS 8'h00
`define DMA_TX_STATUS_OFS 8'h04
`define DMA_TX_CUR_DESC_LOW_OFS 8'h08
`define DMA_TX_CUR_DESC_HIGH_OFS 8'h0C
`define DMA_TX_TAIL_DESC_LOW_OFS 8'h10
`define DMA_TX_TAIL_DESC_HIGH_OFS 8'h14
`define DMA_TX_SOURCE_LOW_OFS 8'h18
`define DMA_TX_SOURCE_HIGH_OFS 8'h1C
`define DMA_TX_LENGTH_OFS 8'h28
`define DMA_CHAIN_ATTR_OFS 8'h2C
`define DMA_RX_CONTROL_OFS 8'h30
`define DMA_RX_STATUS_OFS 8'h34
`define DMA_RX_CUR_DESC_LOW_OFS 8'h38
`define DMA_RX_CUR_DESC_HIGH_OFS 8'h3C
`define DMA_RX_TAIL_DESC_LOW_OFS 8'h40
`define DMA_RX_TAIL_DESC_HIGH_OFS 8'h44
`define DMA_RX_DEST_LOW_OFS 8'h48
`define DMA_RX_DEST_HIGH_OFS 8'h4C
`define DMA_RX_LENGTH_OFS 8'h58

`define DMA_CHANNEL_STRIDE 8'h30
`define DMA_REG_SPAN 32'h0000_0060

`define DMA_CONTROL_RESET 32'h0000_0002
`define DMA_CONTROL_RO_MASK 32'h0000_0002
`define DMA_CONTROL_RUN_BIT 0
`define DMA_WORD_RESET 32'h0000_0000

`define DMA_STATUS_HALTED_BIT 0
`define DMA_STATUS_IDLE_BIT 1
`define DMA_STATUS_EVENT_LSB 12
`define DMA_EVENT_W 3

`define DMA_RESP_OKAY 2'h0

`endif

//--- hdl/dma_regs_pkg.sv
// Types shared by the DMA register bank
package dma_regs_pkg;
  typedef logic [31:0] reg_word_t;
  typedef logic [7:0] reg_offset_t;
  typedef logic [2:0] event_bits_t;
  typedef enum logic [1:0] {
    CHAN_TX = 2'b01,
    CHAN_RX = 2'b10
  } channel_t;
endpackage : dma_regs_pkg

//--- testbench/dma_host_model.sv
// Host model issuing single-word register writes and reads
`timescale 1ns/1ps
module dma_host_model (
  input wire logic clk_in,
  output logic [31:0] awaddr_out,
  output logic awvalid_out,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  output logic bready_out,
  output logic [31:0] araddr_out,
  output logic arvalid_out,
  output logic rready_out,
  input wire logic wready_in,
  input wire logic bvalid_in,
  input wire logic arready_in,
  input wire logic rvalid_in
);
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    {awaddr_out, wdata_out, araddr_out, wstrb_out} = 100'h0;
  end
  task automatic write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                       input bit slow);
    @(negedge clk_in);
    awaddr_out = a;
    wdata_out = d;
    wstrb_out = s;
    {awvalid_out, wvalid_out} = 2'h3;
    @(posedge clk_in);
    while (!wready_in) @(posedge clk_in);
    @(negedge clk_in);
    {awvalid_out, wvalid_out} = 2'h0;
    // Released lines show garbage, not the last value
    awaddr_out = ~a;
    wdata_out = ~d;
    if (slow) repeat (2) @(negedge clk_in);
    bready_out = 1'b1;
    @(posedge clk_in);
    while (!bvalid_in) @(posedge clk_in);
    @(negedge clk_in);
    bready_out = 1'b0;
  endtask : write
  task automatic read(input logic [31:0] a, input bit slow);
    @(negedge clk_in);
    araddr_out = a;
    arvalid_out = 1'b1;
    @(posedge clk_in);
    while (!arready_in) @(posedge clk_in);
    @(negedge clk_in);
    arvalid_out = 1'b0;
    araddr_out = ~a;
    if (slow) repeat (2) @(negedge clk_in);
    rready_out = 1'b1;
    @(posedge clk_in);
    while (!rvalid_in) @(posedge clk_in);
    @(negedge clk_in);
    rready_out = 1'b0;
  endtask : read
endmodule : dma_host_model

//--- testbench/dma_register_map_asserts.sv
// Bus handshake and register behaviour checks for the DMA register bank
`timescale 1ns/1ps
module dma_register_map_checker (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic AWVALID_IN,
  input wire logic WVALID_IN,
  input wire logic AWREADY_OUT,
  input wire logic WREADY_OUT,
  input wire logic [1:0] BRESP_OUT,
  input wire logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic [1:0] RRESP_OUT,
  input wire logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire logic TX_START_OUT,
  input wire logic [31:0] TX_CONTROL_OUT,
  input wire logic [31:0] RX_CONTROL_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  ready_pair_a: assert property (AWREADY_OUT == WREADY_OUT)
    else $error("write readies split");
  write_cause_a: assert property (AWREADY_OUT |-> $past(AWVALID_IN) && $past(WVALID_IN)
    && !$past(BVALID_OUT)) else $error("write taken without both valids");
  write_answer_a: assert property (AWREADY_OUT |=> BVALID_OUT && BRESP_OUT == 2'h0)
    else $error("write response missing or not okay");
  resp_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT)
    else $error("write response dropped early");
  read_answer_a: assert property (ARREADY_OUT |=> RVALID_OUT && RRESP_OUT == 2'h0)
    else $error("read response missing or not okay");
  read_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read data not held");
  read_single_a: assert property (RVALID_OUT |-> !ARREADY_OUT)
    else $error("second read taken while answering");
  ctl_fixed_a: assert property (TX_CONTROL_OUT[1] && RX_CONTROL_OUT[1])
    else $error("control bit 1 not one");
  start_cause_a: assert property (TX_START_OUT |-> $past(AWREADY_OUT) ##1 !TX_START_OUT)
    else $error("start pulse without write or too long");
  cover property (AWREADY_OUT);
  cover property (ARREADY_OUT);
  cover property (TX_START_OUT);
  cover property (BVALID_OUT && !BREADY_IN);
endmodule : dma_register_map_checker

bind dma_register_map dma_register_map_checker u_checker (.CORE_CLK_IN, .RESET_N_IN,
  .AWVALID_IN, .WVALID_IN, .AWREADY_OUT, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN,
  .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN, .TX_START_OUT,
  .TX_CONTROL_OUT, .RX_CONTROL_OUT);

//--- testbench/dma_register_map_tb_top.sv
// Self-checking bench for the DMA register bank driven by the host model
`timescale 1ns/1ps
`define CHK(g, e) check_eq(34'(g), 34'(e))
module dma_register_map_tb_top;
  localparam logic [31:0] BASE = 32'h4000_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic tx_idle, rx_idle, tx_start;
  logic [1:0] bresp, rresp;
  logic [2:0] tx_ev, rx_ev;
  logic [3:0] wstrb;
  logic [31:0] awaddr, wdata, araddr, rdata, tx_ctl, rx_ctl, tx_lo, tx_hi, rx_hi, attr;
  logic awvalid2, wvalid2, bready2, arvalid2, rready2, wready2, bvalid2, arready2, rvalid2;
  logic rx_start, tx_start2, rx_start2;
  logic [1:0] bresp2, rresp2;
  logic [3:0] wstrb2;
  logic [31:0] awaddr2, wdata2, araddr2, rdata2, rx_lo, rx_lo2, tx_len2, rx_len2;
  logic [31:0] dofs[6] = '{32'h18, 32'h1C, 32'h28, 32'h48, 32'h4C, 32'h58};
  // Offsets that direct mode leaves unimplemented, tail pointers included
  logic [31:0] dres[5] = '{32'h08, 32'h10, 32'h3C, 32'h40, 32'h2C};
  bit direct = 1'b0;
  int starts = 0;
  logic [33:0] exp_q[$];
  logic [31:0] rs = 32'h89E98089;
  logic [31:0] ofs[8] = '{32'h08, 32'h0C, 32'h10, 32'h14, 32'h38, 32'h3C, 32'h40, 32'h44};
  // Offsets below are unused in chaining mode or misaligned; the last wraps past the base to land at absolute 0x08
  logic [31:0] um[9] = '{32'h20, 32'h18, 32'h1C, 32'h28, 32'h48, 32'h58, 32'h5C, 32'h09,
                         32'hC000_0008};
  logic [31:0] val[8];
  int fail_count = 0;
  int checks = 0;

  always #20 clk = ~clk;

  dma_register_map #(.REGISTER_BASE_PARAMETER(BASE), .CHAINING_MODE(1'b1),
                     .MULTICHANNEL(1'b1)) DUT (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .TX_IDLE_IN(tx_idle),
    .RX_IDLE_IN(rx_idle), .TX_EVENT_IN(tx_ev), .RX_EVENT_IN(rx_ev), .TX_CONTROL_OUT(tx_ctl),
    .RX_CONTROL_OUT(rx_ctl), .TX_ADDR_LOW_OUT(tx_lo), .TX_ADDR_HIGH_OUT(tx_hi),
    .RX_ADDR_LOW_OUT(rx_lo), .RX_ADDR_HIGH_OUT(rx_hi), .TX_LENGTH_OUT(), .RX_LENGTH_OUT(),
    .TX_START_OUT(tx_start), .RX_START_OUT(rx_start), .CHAIN_ATTR_OUT(attr));

  dma_register_map #(.REGISTER_BASE_PARAMETER(BASE), .CHAINING_MODE(1'b0),
                     .MULTICHANNEL(1'b0)) DUT_DIRECT (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .AWADDR_IN(awaddr2), .AWVALID_IN(awvalid2),
    .AWREADY_OUT(), .WDATA_IN(wdata2), .WSTRB_IN(wstrb2), .WVALID_IN(wvalid2),
    .WREADY_OUT(wready2), .BRESP_OUT(bresp2), .BVALID_OUT(bvalid2), .BREADY_IN(bready2),
    .ARADDR_IN(araddr2), .ARVALID_IN(arvalid2), .ARREADY_OUT(arready2), .RDATA_OUT(rdata2),
    .RRESP_OUT(rresp2), .RVALID_OUT(rvalid2), .RREADY_IN(rready2), .TX_IDLE_IN(tx_idle),
    .RX_IDLE_IN(rx_idle), .TX_EVENT_IN(tx_ev), .RX_EVENT_IN(rx_ev), .TX_CONTROL_OUT(),
    .RX_CONTROL_OUT(), .TX_ADDR_LOW_OUT(), .TX_ADDR_HIGH_OUT(), .RX_ADDR_LOW_OUT(rx_lo2),
    .RX_ADDR_HIGH_OUT(), .TX_LENGTH_OUT(tx_len2), .RX_LENGTH_OUT(rx_len2),
    .TX_START_OUT(tx_start2), .RX_START_OUT(rx_start2), .CHAIN_ATTR_OUT());

  dma_host_model host2 (.clk_in(clk), .awaddr_out(awaddr2), .awvalid_out(awvalid2),
    .wdata_out(wdata2), .wstrb_out(wstrb2), .wvalid_out(wvalid2), .bready_out(bready2),
    .araddr_out(araddr2), .arvalid_out(arvalid2), .rready_out(rready2), .wready_in(wready2),
    .bvalid_in(bvalid2), .arready_in(arready2), .rvalid_in(rvalid2));

  dma_host_model host (.clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid),
    .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .bready_out(bready),
    .araddr_out(araddr), .arvalid_out(arvalid), .rready_out(rready), .wready_in(wready),
    .bvalid_in(bvalid), .arready_in(arready), .rvalid_in(rvalid));

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs

  task automatic check_eq(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask : check_eq

  task automatic give_verdict();
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Random strobes on every write and random host pacing on every access
  task automatic wr(input logic [31:0] o, input logic [31:0] d);
    logic [3:0] s;
    s = 4'(xs());
    exp_q.push_back(34'h0);
    if (direct) host2.write(BASE + o, d, s, rs[9]);
    else host.write(BASE + o, d, s, rs[9]);
  endtask : wr

  task automatic rd(input logic [31:0] o, input logic [31:0] e);
    void'(xs());
    exp_q.push_back({2'h0, e});
    if (direct) host2.read(BASE + o, rs[7]);
    else host.read(BASE + o, rs[7]);
  endtask : rd

  always @(posedge clk) begin
    if (bvalid && bready) `CHK({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) `CHK({rresp, rdata}, exp_q.pop_front());
    if (bvalid2 && bready2) `CHK({bresp2, 32'h0}, exp_q.pop_front());
    if (rvalid2 && rready2) `CHK({rresp2, rdata2}, exp_q.pop_front());
    starts <= starts + int'(tx_start) + int'(rx_start) + int'(tx_start2) + int'(rx_start2);
  end

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    logic [31:0] d;
    {tx_idle, rx_idle, tx_ev, rx_ev} = 8'h80;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd(32'h00, 32'h0000_0002);
    rd(32'h30, 32'h0000_0002);
    rd(32'h04, 32'h0000_0003);
    rd(32'h34, 32'h0000_0001);
    @(negedge clk);
    {tx_ev, rx_ev} = 6'h2A;
    @(negedge clk);
    {tx_ev, rx_ev} = 6'h00;
    rd(32'h04, 32'h0000_5003);
    rd(32'h34, 32'h0000_2001);
    wr(32'h04, 32'h0000_1003);
    rd(32'h04, 32'h0000_4003);
    wr(32'h00, 32'h0000_0000);
    rd(32'h00, 32'h0000_0002);
    wr(32'h00, 32'h0000_0001);
    rd(32'h04, 32'h0000_4002);
    d = xs() & 32'hFFFF_FFFB;
    wr(32'h30, d);
    rd(32'h30, d | 32'h2);
    `CHK(rx_ctl, d | 32'h2);
    foreach (ofs[i]) begin
      val[i] = xs();
      wr(ofs[i], val[i]);
      rd(ofs[i], val[i]);
    end
    `CHK(rx_hi, val[5]);
    `CHK(rx_lo, val[4]);
    foreach (um[i]) begin
      wr(um[i], 32'hFFFF_FFFF);
      rd(um[i], 32'h0);
    end
    // Multichannel chaining build: the attribute word exists
    wr(32'h2C, val[1]);
    rd(32'h2C, val[1]);
    `CHK(attr, val[1]);
    `CHK(tx_lo, val[0]);
    wr(32'h0C, 32'h4433_2211);
    `CHK(tx_hi[7:0], 8'h11);
    `CHK(tx_hi[31:24], 8'h44);
    // Direct-mode bank: buffer words live, pointer and attribute offsets empty
    direct = 1'b1;
    foreach (dofs[i]) begin
      val[i] = xs();
      wr(dofs[i], val[i]);
      rd(dofs[i], val[i]);
    end
    foreach (dres[i]) begin
      wr(dres[i], 32'hFFFF_FFFF);
      rd(dres[i], 32'h0);
    end
    `CHK(tx_len2, val[2]);
    `CHK(rx_lo2, val[3]);
    `CHK(rx_len2, val[5]);
    `CHK(starts, 4);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    rd(32'h28, 32'h0);
    direct = 1'b0;
    rd(32'h08, 32'h0);
    give_verdict();
  end
endmodule : dma_register_map_tb_top
